// >>> dstu_timer.v
/*
 * Dual sixteen-bit down-counting timer unit with AHB-Lite register slave.
 * Assumes a single 20 MHz clock; oscillator and event pins are asynchronous.
 */
// Implementation choices: register access over AHB-Lite and the address map.
// Summary of operation
// - Timers count down; after zero the next pulse reloads from latch.
// - Every underflow sets that timer's request flag.
// - Count source is main oscillator over 16, or sub oscillator over 16 in low speed.
// - Pulse-output mode toggles event pin A on every underflow.
// - Event-counter mode counts edges of the timer's own pin.
// - Pulse-width mode counts divided clock while pin A at selected level.
// - Write-control 0 loads counter and latch together.
// - Write-control 1 loads latch only; counter takes it at underflow.
// - Enabled real-time port outputs stored bits at each timer A underflow.
// - Enable rising after new data outputs that data at once.
// - Data rewritten while enabled waits for next timer A underflow.
// - Event pin A request edge follows its edge-select setting.
// - Period mode: selected pin B edge raises request and reloads.
// - Measurement modes capture pre-reload count, held until read once.
// - High/low width mode reloads and requests on both edges.
// - Request flags clear by software write, set only by hardware.
// - Priorities: underflow A 6, underflow B 7, pin A 10, pin B 11.
// - Pin B request edge follows edge-select except in high/low mode.
`timescale 1ns/10ps
`default_nettype none
`include "dstu_defines.vh"

module dstu_timer
(
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire        i_main_osc_input,
  input  wire        i_sub_osc_input,
  input  wire        i_event_pin_a,
  input  wire        i_event_pin_b,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         o_event_pin_a,
  output reg         o_event_pin_a_oe_n,
  output reg         o_realtime_out_bit0,
  output reg         o_realtime_out_bit1,
  output reg  [3:0]  o_irq_req
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [15:0] cnt_a_r;
  reg  [15:0] lat_a_r;
  reg  [15:0] cnt_b_r;
  reg  [15:0] lat_b_r;
  reg  [15:0] cap_b_r;
  reg         cap_vld_r;
  reg  [7:0]  mode_a_r;
  reg  [7:0]  mode_b_r;
  reg         lowspd_r;
  reg  [3:0]  req_r;
  reg  [`DSTU_PRE_W-1:0] pre_r;
  reg         dp_wr_r;
  reg  [11:0] dp_addr_r;
  wire        main_rise;
  wire        sub_rise;
  wire        pa_lvl;
  wire        pa_rise;
  wire        pa_fall;
  wire        pb_rise;
  wire        pb_fall;
  wire        tick;
  wire        addr_ph;
  wire [1:0]  mode_a;
  wire [1:0]  mode_b;
  wire        pulse_a;
  wire        pulse_b;
  wire        uf_a;
  wire        uf_b;
  wire        edge_a;
  wire        edge_b;
  wire        meas_b;
  wire        reload_b;
  wire        wr_tmra;
  wire        wr_tmrb;
  wire        wr_modea;
  wire        rd_tmrb;

  // Chosen-edge helper, shared by both event pins.
  function sel_edge;
    input rise;
    input fall;
    input falling_sel;
    begin
      sel_edge = falling_sel ? fall : rise;
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  dstu_pin_sync u_sync_main
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_main_osc_input),
    .o_level   (),
    .o_rise    (main_rise),
    .o_fall    ()
  );

  dstu_pin_sync u_sync_sub
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_sub_osc_input),
    .o_level   (),
    .o_rise    (sub_rise),
    .o_fall    ()
  );

  dstu_pin_sync u_sync_pa
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_event_pin_a),
    .o_level   (pa_lvl),
    .o_rise    (pa_rise),
    .o_fall    (pa_fall)
  );

  dstu_pin_sync u_sync_pb
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_event_pin_b),
    .o_level   (),
    .o_rise    (pb_rise),
    .o_fall    (pb_fall)
  );

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // oscillator over sixteen
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      pre_r <= {`DSTU_PRE_W{1'b0}};
    else if (lowspd_r ? sub_rise : main_rise)
      pre_r <= pre_r + 1'b1;
  end

  // The oscillator must run well below half the system clock to be seen.
  assign tick = (lowspd_r ? sub_rise : main_rise) && (&pre_r);

  // ****************************************************************
  // Count pulse selection
  // ****************************************************************
  assign mode_a = mode_a_r[`DSTU_MA_MODE_LO+1:`DSTU_MA_MODE_LO];
  assign mode_b = mode_b_r[1:0];

  assign pulse_a = mode_a_r[`DSTU_MA_STOP] ? 1'b0 :
                   (mode_a == `DSTU_MODE_EVENT) ?
                     sel_edge(pa_rise, pa_fall, mode_a_r[`DSTU_MA_EDGE]) :
                   (mode_a == `DSTU_MODE_WIDTH) ?
                     (tick && (pa_lvl ^ mode_a_r[`DSTU_MA_EDGE])) : tick;
  assign pulse_b = mode_b_r[`DSTU_MB_STOP] ? 1'b0 :
                   (mode_b == `DSTU_MODE_EVENT) ?
                     sel_edge(pb_rise, pb_fall, mode_b_r[`DSTU_MB_EDGE]) : tick;

  assign uf_a = pulse_a && (cnt_a_r == 16'h0000);
  assign uf_b = pulse_b && (cnt_b_r == 16'h0000);

  assign edge_a = sel_edge(pa_rise, pa_fall, mode_a_r[`DSTU_MA_EDGE]);
  assign edge_b = (mode_b == `DSTU_MODE_HLWIDTH) ? (pb_rise || pb_fall) :
                  sel_edge(pb_rise, pb_fall, mode_b_r[`DSTU_MB_EDGE]);
  assign meas_b   = (mode_b == `DSTU_MODE_PERIOD) || (mode_b == `DSTU_MODE_HLWIDTH);
  assign reload_b = meas_b && edge_b;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  assign addr_ph  = hsel && hready && htrans[1];
  assign wr_tmra  = dp_wr_r && (dp_addr_r == `DSTU_OFS_TMRA);
  assign wr_tmrb  = dp_wr_r && (dp_addr_r == `DSTU_OFS_TMRB);
  assign wr_modea = dp_wr_r && (dp_addr_r == `DSTU_OFS_MODEA);
  assign rd_tmrb  = addr_ph && !hwrite && (haddr[11:0] == `DSTU_OFS_TMRB);

  // Single-cycle answer: read data is registered at the address phase.
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dp_wr_r   <= addr_ph && hwrite;
      dp_addr_r <= haddr[11:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ph && !hwrite)
      begin
        if (haddr[11:0] == `DSTU_OFS_TMRA)
          hrdata <= {16'h0000, cnt_a_r};
        else if (haddr[11:0] == `DSTU_OFS_TMRB)
          hrdata <= {16'h0000, cap_vld_r ? cap_b_r : cnt_b_r};
        else if (haddr[11:0] == `DSTU_OFS_MODEA)
          hrdata <= {24'h000000, mode_a_r};
        else if (haddr[11:0] == `DSTU_OFS_MODEB)
          hrdata <= {24'h000000, mode_b_r};
        else if (haddr[11:0] == `DSTU_OFS_REQ)
          hrdata <= {28'h0000000, req_r};
        else if (haddr[11:0] == `DSTU_OFS_CTRL)
          hrdata <= {31'h00000000, lowspd_r};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      mode_a_r  <= `DSTU_MODE_RST;
      mode_b_r  <= `DSTU_MODE_RST;
      lowspd_r  <= 1'b0;
    end
    else
    begin
      if (wr_modea)
        mode_a_r <= hwdata[7:0];
      if (dp_wr_r && (dp_addr_r == `DSTU_OFS_MODEB))
        mode_b_r <= hwdata[7:0];
      if (dp_wr_r && (dp_addr_r == `DSTU_OFS_CTRL))
        lowspd_r <= hwdata[`DSTU_CTRL_LOWSPD];
    end
  end

  // ****************************************************************
  // Timer A
  // ****************************************************************
  // Whole-word writes rule out a torn latch update against an underflow.
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cnt_a_r <= `DSTU_TMR_RST;
      lat_a_r <= `DSTU_TMR_RST;
    end
    else
    begin
      if (uf_a)
        cnt_a_r <= lat_a_r;
      else if (pulse_a)
        cnt_a_r <= cnt_a_r - 16'h0001;
      if (wr_tmra)
      begin
        lat_a_r <= hwdata[15:0];
        if (!mode_a_r[`DSTU_MA_WRCTL])
          cnt_a_r <= hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Timer B with capture
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cnt_b_r   <= `DSTU_TMR_RST;
      lat_b_r   <= `DSTU_TMR_RST;
      cap_b_r   <= 16'h0000;
      cap_vld_r <= 1'b0;
    end
    else
    begin
      if (reload_b || uf_b)
        cnt_b_r <= lat_b_r;
      else if (pulse_b)
        cnt_b_r <= cnt_b_r - 16'h0001;
      if (wr_tmrb)
      begin
        lat_b_r <= hwdata[15:0];
        cnt_b_r <= hwdata[15:0];
      end
      if (reload_b)
      begin
        cap_b_r   <= cnt_b_r;
        cap_vld_r <= 1'b1;
      end
      else if (rd_tmrb)
        cap_vld_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Request flags and outputs
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      req_r               <= 4'h0;
      o_irq_req           <= 4'h0;
      o_event_pin_a       <= 1'b0;
      o_event_pin_a_oe_n  <= 1'b1;
      o_realtime_out_bit0 <= 1'b0;
      o_realtime_out_bit1 <= 1'b0;
    end
    else
    begin
      req_r <= (req_r & ~((dp_wr_r && (dp_addr_r == `DSTU_OFS_REQ)) ?
                          hwdata[3:0] : 4'h0))
             | {edge_b, edge_a, uf_b, uf_a};
      o_irq_req <= req_r;
      o_event_pin_a_oe_n <= (mode_a != `DSTU_MODE_PULSE);
      if (mode_a == `DSTU_MODE_PULSE && uf_a)
        o_event_pin_a <= !o_event_pin_a;
      if (wr_modea && hwdata[`DSTU_MA_RTP_EN] && !mode_a_r[`DSTU_MA_RTP_EN])
      begin
        o_realtime_out_bit0 <= hwdata[`DSTU_MA_RTP_D0];
        o_realtime_out_bit1 <= hwdata[`DSTU_MA_RTP_D1];
      end
      else if (mode_a_r[`DSTU_MA_RTP_EN] && uf_a)
      begin
        o_realtime_out_bit0 <= mode_a_r[`DSTU_MA_RTP_D0];
        o_realtime_out_bit1 <= mode_a_r[`DSTU_MA_RTP_D1];
      end
    end
  end

endmodule // dstu_timer

`default_nettype wire

// >>> dstu_defines.vh
/*
 * Register map, field positions, reset values and timing constants of the
 * dual sixteen-bit timer unit.
 * Assumes a 20 MHz system clock and 32-bit AHB-Lite register access.
 */
`ifndef DSTU_DEFINES_VH
`define DSTU_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DSTU_OFS_TMRA      12'h000
`define DSTU_OFS_TMRB      12'h004
`define DSTU_OFS_MODEA     12'h008
`define DSTU_OFS_MODEB     12'h00C
`define DSTU_OFS_REQ       12'h010
`define DSTU_OFS_CTRL      12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define DSTU_MA_MODE_LO    0
`define DSTU_MA_WRCTL      2
`define DSTU_MA_RTP_D0     3
`define DSTU_MA_RTP_D1     4
`define DSTU_MA_RTP_EN     5
`define DSTU_MA_EDGE       6
`define DSTU_MA_STOP       7
`define DSTU_MB_EDGE       6
`define DSTU_MB_STOP       7
`define DSTU_REQ_UFA       0
`define DSTU_REQ_UFB       1
`define DSTU_REQ_EVA       2
`define DSTU_REQ_EVB       3
`define DSTU_CTRL_LOWSPD   0

// ****************************************************************
// Mode encodings and reset values
// ****************************************************************
`define DSTU_MODE_TIMER    2'b00
`define DSTU_MODE_PULSE    2'b01
`define DSTU_MODE_EVENT    2'b10
`define DSTU_MODE_WIDTH    2'b11
`define DSTU_MODE_PERIOD   2'b01
`define DSTU_MODE_HLWIDTH  2'b11
`define DSTU_TMR_RST       16'hFFFF
`define DSTU_MODE_RST      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define DSTU_PRESCALE      16
`define DSTU_PRE_W         4

`endif

// >>> dstu_pin_sync.v
/*
 * Three-stage synchroniser with edge detection for one event pin.
 * Assumes the pin is asynchronous to i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module dstu_pin_sync
(
  input  wire i_clk_sys,
  input  wire i_rst,
  input  wire i_pin,
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);

  reg [2:0] sync_r;

  // ****************************************************************
  // Sampling
  // ****************************************************************
  // sampled edge detect
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sync_r  <= 3'h0;
      o_level <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], i_pin};
      // The level only moves once the second and third stages agree.
      if (sync_r[1] == sync_r[2])
        o_level <= sync_r[2];
    end
  end

  assign o_rise = (sync_r[1] == sync_r[2]) && sync_r[2] && !o_level;
  assign o_fall = (sync_r[1] == sync_r[2]) && !sync_r[2] && o_level;

endmodule // dstu_pin_sync

`default_nettype wire

// >>> dstu_props.sv
/*
 * Checker of the timer unit's bus slave, request flags and event pins.
 * Assumes it is bound to dstu_timer and sees only that module's ports.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dstu_defines.vh"

module dstu_props
(
  input wire        i_clk_sys,
  input wire        i_rst,
  input wire        i_event_pin_a,
  input wire        i_event_pin_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        o_event_pin_a,
  input wire        o_event_pin_a_oe_n,
  input wire [3:0]  o_irq_req
);
  // ****************************************************************
  // Shadow of the mode registers, rebuilt from bus writes
  // ****************************************************************
  reg  [11:0] dph_a_r;
  reg         dph_w_r;
  reg  [7:0]  mode_a_r;
  reg  [7:0]  mode_b_r;
  wire        take = hsel & hready & htrans[1];
  wire        req_w = dph_w_r && (dph_a_r == `DSTU_OFS_REQ);

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      dph_w_r <= 1'b0;
      dph_a_r <= 12'h000;
      mode_a_r <= 8'h00;
      mode_b_r <= 8'h00;
    end
    else
    begin
      dph_w_r <= take & hwrite;
      dph_a_r <= haddr[11:0];
      if (dph_w_r && (dph_a_r == `DSTU_OFS_MODEA))
        mode_a_r <= hwdata[7:0];
      if (dph_w_r && (dph_a_r == `DSTU_OFS_MODEB))
        mode_b_r <= hwdata[7:0];
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_rd_take;
    take && !hwrite;
  endsequence
  sequence s_mode_a_still;
    $stable(mode_a_r) [*4];
  endsequence
  sequence s_edge_b;
    (mode_b_r[1:0] == `DSTU_MODE_HLWIDTH) ? $changed(i_event_pin_b) :
      (mode_b_r[6] ? $fell(i_event_pin_b) : $rose(i_event_pin_b));
  endsequence

  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_rdata_hold:
    assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero:
    assert property (s_rd_take ##0 (haddr[11:0] > `DSTU_OFS_CTRL) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_flag_clear:
    assert property (req_w |-> ##2 ((o_irq_req & $past(hwdata[3:0], 2)) == 4'h0))
    else $error("request flag not cleared");
  a_eva_edge:
    assert property ((mode_a_r[6] ? $fell(i_event_pin_a) : $rose(i_event_pin_a))
      |-> ##[1:8] o_irq_req[2])
    else $error("pin a edge raised no request");
  a_evb_edge:
    assert property (s_edge_b |-> ##[1:8] o_irq_req[3])
    else $error("pin b edge raised no request");
  a_pin_drive:
    assert property (s_mode_a_still |->
      o_event_pin_a_oe_n == (mode_a_r[1:0] != `DSTU_MODE_PULSE))
    else $error("pin a drive enable wrong");
  a_pulse_toggle:
    assert property ($rose(o_irq_req[0]) && !o_event_pin_a_oe_n |->
      ##[0:2] (o_event_pin_a != $past(o_event_pin_a, 4)))
    else $error("pin a did not toggle on underflow");
endmodule // dstu_props

bind dstu_timer dstu_props u_props
(
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_event_pin_a(i_event_pin_a),
  .i_event_pin_b(i_event_pin_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .o_event_pin_a(o_event_pin_a),
  .o_event_pin_a_oe_n(o_event_pin_a_oe_n), .o_irq_req(o_irq_req)
);
`default_nettype wire

// >>> dstu_ext.sv
/*
 * Far-side model: both oscillators and the two event pin drivers.
 * Assumes the bench sets the wanted pin levels on i_lvl.
 */
`timescale 1ns/10ps
`default_nettype none

module dstu_ext
(
  input  wire       i_clk_sys,
  input  wire [1:0] i_lvl,
  output reg        o_main_osc,
  output reg        o_sub_osc,
  output reg  [1:0] o_pin
);
  // ****************************************************************
  // Oscillators and pins, moved on the falling clock edge
  // ****************************************************************
  reg [2:0] div_r;

  initial
  begin
    div_r = 3'h0;
    o_main_osc = 1'b0;
    o_sub_osc = 1'b0;
    o_pin = 2'h0;
  end

  // Main period is four clocks and sub eight, so each main level stands two samples and each sub level four.
  always @(negedge i_clk_sys)
  begin
    div_r <= div_r + 3'h1;
    o_main_osc <= div_r[1];
    o_sub_osc <= div_r[2];
    o_pin <= i_lvl;
  end
endmodule // dstu_ext
`default_nettype wire

// >>> testbench.sv
/*
 * Self-checking bench of the timer unit: bus tasks, pin stimulus, checks.
 * Assumes a zero-wait-state slave and the far-side model dstu_ext.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dstu_defines.vh"

module testbench;
  // ****************************************************************
  // Signals, design and far side
  // ****************************************************************
  reg         clk;
  reg         rst;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [1:0]  lv;
  reg  [31:0] rd;
  reg  [31:0] seed;
  reg         p0;
  wire [31:0] hrdata;
  wire        rdy;
  wire        resp;
  wire        pa;
  wire        pa_oe_n;
  wire        rt0;
  wire        rt1;
  wire        mo;
  wire        so;
  wire [1:0]  pin;
  wire [3:0]  irq;
  integer     fails;
  integer     tests_run;
  integer     n;
  integer     k;
  integer     t0;

  dstu_ext u_ext (.i_clk_sys(clk), .i_lvl(lv), .o_main_osc(mo), .o_sub_osc(so), .o_pin(pin));
  dstu_timer dut
  (
    .i_clk_sys(clk), .i_rst(rst), .i_main_osc_input(mo), .i_sub_osc_input(so),
    .i_event_pin_a(pin[0]), .i_event_pin_b(pin[1]), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .o_event_pin_a(pa),
    .o_event_pin_a_oe_n(pa_oe_n), .o_realtime_out_bit0(rt0), .o_realtime_out_bit1(rt1),
    .o_irq_req(irq)
  );

  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  function integer per(input integer ls);
    per = (ls ? 8 : 4) * `DSTU_PRESCALE;
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task cyc(input integer m);
    repeat (m) @(posedge clk);
  endtask

  // A timer moves as one whole word, so byte order cannot go wrong.
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (rdy !== 1'b1)
        @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1)
        @(posedge clk);
      rd = hrdata;
    end
  endtask

  task wt(input integer b);
    begin
      t0 = 0;
      while (irq[b] !== 1'b1 && t0 < 3000)
      begin
        @(posedge clk);
        t0 = t0 + 1;
      end
      if (t0 >= 3000)
      begin
        fails = fails + 1;
        $display("MISMATCH %0t request %0d wait timed out", $time, b);
      end
    end
  endtask

  task edges(input [1:0] msk, input integer m);
    repeat (2 * m)
    begin
      lv <= lv ^ msk;
      cyc(8);
    end
  endtask

  task wrap_up;
    begin
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far beyond the few thousand cycles the run needs.
  initial
  begin
    #1000000;
    fails = fails + 1;
    wrap_up;
  end

  initial
  begin
    fails = 0;
    tests_run = 0;
    seed = 32'h00004859;
    rst = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lv = 2'h0;
    cyc(12);
    rst <= 1'b0;
    @(posedge clk);
    chk(irq, 4'h0);
    chk(pa_oe_n, 1'b1);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd, {16'h0, `DSTU_TMR_RST});
    bus(0, `DSTU_OFS_MODEB, 0);
    chk(rd, {24'h0, `DSTU_MODE_RST});
    seed = xs(seed);
    bus(0, 12'h018 + {seed[5:0], 2'b00}, 0);
    chk(rd, 32'h0);
    for (k = 0; k < 2; k = k + 1)
    begin
      seed = xs(seed);
      n = 2 + seed[1:0];
      bus(1, `DSTU_OFS_CTRL, k);
      bus(1, `DSTU_OFS_TMRA, n);
      bus(1, `DSTU_OFS_REQ, 32'hF);
      wt(0);
      chk(t0 >= n * per(k) - 8 && t0 <= (n + 1) * per(k) + 12, 1);
      chk(irq[0], 1);
      bus(1, `DSTU_OFS_REQ, 32'hF);
      bus(0, `DSTU_OFS_TMRA, 0);
      chk(rd <= n, 1);
    end
    bus(1, `DSTU_OFS_CTRL, 0);
    bus(1, `DSTU_OFS_MODEA, 32'h04);
    bus(1, `DSTU_OFS_TMRA, 32'hF0);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd <= n, 1);
    wt(0);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd >= 32'hE8 && rd <= 32'hF0, 1);
    bus(1, `DSTU_OFS_MODEA, 0);
    bus(1, `DSTU_OFS_TMRA, 32'h300);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd >= 32'h2FF && rd <= 32'h300, 1);
    bus(1, `DSTU_OFS_MODEA, `DSTU_MODE_PULSE);
    bus(1, `DSTU_OFS_TMRA, 3);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    p0 = pa;
    wt(0);
    cyc(4);
    chk(pa, !p0);
    chk(pa_oe_n, 0);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    bus(1, `DSTU_OFS_MODEA, 32'h29);
    cyc(2);
    chk({rt1, rt0}, 2'b01);
    bus(1, `DSTU_OFS_MODEA, 32'h31);
    cyc(2);
    chk({rt1, rt0}, 2'b01);
    wt(0);
    cyc(3);
    chk({rt1, rt0}, 2'b10);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    bus(1, `DSTU_OFS_MODEA, `DSTU_MODE_EVENT);
    bus(1, `DSTU_OFS_TMRA, 32'h10);
    seed = xs(seed);
    n = 1 + seed[2:0];
    edges(2'b01, n);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd, 32'h10 - n);
    chk(irq[2], 1);
    // Stale request is cleared first, then the new edges follow.
    bus(1, `DSTU_OFS_MODEA, 32'h42);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    lv <= 2'b01;
    cyc(8);
    chk(irq[2], 0);
    lv <= 2'b00;
    cyc(8);
    chk(irq[2], 1);
    bus(1, `DSTU_OFS_MODEA, `DSTU_MODE_WIDTH);
    bus(1, `DSTU_OFS_TMRA, 32'h100);
    cyc(200);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd, 32'h100);
    lv <= 2'b01;
    cyc(200);
    bus(0, `DSTU_OFS_TMRA, 0);
    chk(rd < 32'h100 && rd >= 32'hF8, 1);
    lv <= 2'b00;
    bus(1, `DSTU_OFS_MODEA, `DSTU_MODE_EVENT);
    bus(1, `DSTU_OFS_MODEB, `DSTU_MODE_PERIOD);
    bus(1, `DSTU_OFS_TMRB, 32'h100);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    cyc(300);
    lv <= 2'b10;
    cyc(8);
    chk(irq[3], 1);
    bus(0, `DSTU_OFS_TMRB, 0);
    t0 = rd;
    bus(0, `DSTU_OFS_TMRB, 0);
    chk(rd > t0 && t0 <= 32'h100 - 300 / per(0), 1);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    lv <= 2'b00;
    cyc(8);
    chk(irq[3], 0);
    bus(1, `DSTU_OFS_MODEB, `DSTU_MODE_HLWIDTH);
    for (k = 0; k < 2; k = k + 1)
    begin
      bus(1, `DSTU_OFS_REQ, 32'hF);
      lv <= lv ^ 2'b10;
      cyc(8);
      chk(irq[3], 1);
    end
    bus(0, `DSTU_OFS_TMRB, 0);
    bus(1, `DSTU_OFS_MODEB, `DSTU_MODE_EVENT);
    bus(1, `DSTU_OFS_TMRB, 32'h10);
    edges(2'b10, 3);
    bus(0, `DSTU_OFS_TMRB, 0);
    chk(rd, 32'h0D);
    bus(1, `DSTU_OFS_MODEB, `DSTU_MODE_TIMER);
    bus(1, `DSTU_OFS_TMRB, 2);
    bus(1, `DSTU_OFS_REQ, 32'hF);
    wt(1);
    chk(irq[1], 1);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
